// ==== src/fp_est_pkg.sv ====
// Constants, field positions and carrier types for the estimate, round and select datapath.
// Assumes the status register is kept here with bit 0 as its least significant bit.
package fp_est_pkg;
    // Operation decode: primary opcodes and extended opcode values.
    localparam logic [5:0] OP_SINGLE = 6'h3b;
    localparam logic [5:0] OP_DOUBLE = 6'h3f;
    localparam logic [4:0] XO_RECIP_EST = 5'h18;
    localparam logic [4:0] XO_RSQRT_EST = 5'h1a;
    localparam logic [4:0] XO_SELECT = 5'h17;
    localparam logic [9:0] XO_ROUND_SINGLE = 10'h00c;

    // Status register field positions, counted from the least significant bit.
    localparam int POS_EXC_SUMMARY = 31;
    localparam int POS_EN_SUMMARY = 30;
    localparam int POS_INV_SUMMARY = 29;
    localparam int POS_OVERFLOW = 28;
    localparam int POS_UNDERFLOW = 27;
    localparam int POS_DIV0 = 26;
    localparam int POS_INEXACT = 25;
    localparam int POS_SNAN_INV = 24;
    localparam int POS_INV_LO = 19;
    localparam int POS_ROUNDED_UP = 18;
    localparam int POS_INEXACT_RES = 17;
    localparam int POS_CLASS_LO = 12;
    localparam int POS_INV_HI_LO = 8;
    localparam int POS_ROOT_INV = 9;
    localparam int POS_INV_TRAP = 7;
    localparam int POS_OVF_TRAP = 6;
    localparam int POS_UNF_TRAP = 5;
    localparam int POS_DIV0_TRAP = 4;
    localparam int POS_INEXACT_TRAP = 3;
    localparam int POS_ROUND_LO = 0;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // Rounding control encodings.
    localparam logic [1:0] RND_NEAREST = 2'h0;
    localparam logic [1:0] RND_ZERO = 2'h1;
    localparam logic [1:0] RND_POS = 2'h2;
    localparam logic [1:0] RND_NEG = 2'h3;

    // Result class codes.
    localparam logic [4:0] CLS_QNAN = 5'h11;
    localparam logic [4:0] CLS_NEG_INF = 5'h09;
    localparam logic [4:0] CLS_NEG_NORM = 5'h08;
    localparam logic [4:0] CLS_NEG_DENORM = 5'h18;
    localparam logic [4:0] CLS_NEG_ZERO = 5'h12;
    localparam logic [4:0] CLS_POS_ZERO = 5'h02;
    localparam logic [4:0] CLS_POS_DENORM = 5'h14;
    localparam logic [4:0] CLS_POS_NORM = 5'h04;
    localparam logic [4:0] CLS_POS_INF = 5'h05;

    // Format constants.
    localparam logic [63:0] DEFAULT_QNAN = 64'h7ff8_0000_0000_0000;
    localparam logic [10:0] EXP_ONES = 11'h7ff;
    localparam logic signed [12:0] EXP_BIAS = 13'sh03ff;
    localparam logic signed [12:0] SGL_EXP_MAX = 13'sh007f;
    localparam logic signed [12:0] SGL_EXP_MIN = -13'sh007e;

    // Reciprocal root seed: index {exponent parity, four fraction bits}, value 2r-1 in 256ths.
    localparam logic [7:0] RSQRT_SEED [32] = '{
        8'hf8, 8'hea, 8'hdc, 8'hd0, 8'hc4, 8'hba, 8'hb0, 8'ha6,
        8'h9e, 8'h96, 8'h8e, 8'h87, 8'h80, 8'h79, 8'h73, 8'h6d,
        8'h65, 8'h5a, 8'h51, 8'h48, 8'h40, 8'h38, 8'h31, 8'h2b,
        8'h25, 8'h1f, 8'h19, 8'h14, 8'h0f, 8'h0b, 8'h06, 8'h02};

    typedef struct packed {
        logic valid;
        logic [5:0] primary;
        logic [9:0] extended;
        logic record_bit;
        logic [4:0] target;
        logic [63:0] float_source_a;
        logic [63:0] float_source_b;
        logic [63:0] float_source_c;
    } issue_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] target;
        logic [63:0] data;
        logic cond_valid;
        logic [3:0] cond_field_one;
    } result_t;

    typedef struct packed {
        result_t res;
        logic [31:0] status;
    } state_t;
endpackage

// ==== src/fp_estimate_round_select.sv ====
// Estimate, round-to-single and select datapath with its own status and control register.
// Assumes issue logic presents operands already read from the register file, one per cycle.
`timescale 1ns/100ps

// Contract
// - Reciprocal estimate writes single-precision 1/B within one part in 256.
// - Reciprocal root estimate writes 1/sqrt(B) within one part in 32.
// - Zero into reciprocal gives signed infinity, divide-by-zero; no write if trapped.
// - Signaling NaN into reciprocal flags invalid, gives quiet NaN; no write if trapped.
// - Estimates update result class, skipped on trapped invalid or trapped divide.
// - Reciprocal updates overflow, underflow, divide, signaling invalid and summary bits.
// - Root estimate updates divide, signaling invalid, negative root invalid, summary.
// - Round-to-single rounds B to single using the rounding control field.
// - Round-to-single updates class, rounding indicators, sticky and summary bits.
// - Round-to-single sets class unless invalid occurs with invalid trap enabled.
// - Select copies C when A is greater than or equal to zero.
// - Select copies B when A is negative or any NaN.
// - Select treats both zeros as equal, so either zero picks C.
// - Record bit copies three summary bits and overflow into field one; select changes no status.
// - Estimate bit patterns may vary; only the error bound is promised.
module fp_estimate_round_select (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue.
    input wire fp_est_pkg::issue_t issue,
    // Software load of the status register.
    input wire logic status_load,
    input wire logic [31:0] status_load_value,
    // Completion towards the register file and condition register.
    output fp_est_pkg::result_t result,
    // Status register contents.
    output logic [31:0] float_status_control_reg
);
    import fp_est_pkg::*;

    state_t state;
    state_t next_state;

    // Classifies a double-format value into the five-bit result class code.
    function automatic logic [4:0] classify(input logic [63:0] v);
        logic s;
        logic [10:0] e;
        logic fz;
        s = v[63];
        e = v[62:52];
        fz = (v[51:0] == 52'h0);
        if (e == EXP_ONES) begin
            classify = !fz ? CLS_QNAN : (s ? CLS_NEG_INF : CLS_POS_INF);
        end else if (e == 11'h000) begin
            classify = fz ? (s ? CLS_NEG_ZERO : CLS_POS_ZERO)
                          : (s ? CLS_NEG_DENORM : CLS_POS_DENORM);
        end else begin
            classify = s ? CLS_NEG_NORM : CLS_POS_NORM;
        end
    endfunction

    // Operand B fields shared by the three arithmetic operations.
    logic b_sign;
    logic [10:0] b_exp;
    logic [51:0] b_frac;
    logic b_nan;
    logic b_snan;
    logic b_inf;
    logic b_zero;
    logic signed [12:0] b_unb;
    logic [63:0] b_quiet;
    assign b_sign = issue.float_source_b[63];
    assign b_exp = issue.float_source_b[62:52];
    assign b_frac = issue.float_source_b[51:0];
    assign b_nan = (b_exp == EXP_ONES) && (b_frac != 52'h0);
    assign b_snan = b_nan && !b_frac[51];
    assign b_inf = (b_exp == EXP_ONES) && (b_frac == 52'h0);
    assign b_zero = (b_exp == 11'h000) && (b_frac == 52'h0);
    assign b_unb = $signed({2'h0, b_exp}) - EXP_BIAS;
    assign b_quiet = {b_sign, EXP_ONES, 1'b1, b_frac[50:29], 29'h0};

    // Reciprocal: a 24-bit quotient, truncated, is far inside the 1/256 bound.
    logic [47:0] rcp_quot;
    logic rcp_exact;
    logic signed [12:0] rcp_unb;
    assign rcp_quot = 48'h8000_0000_0000 / {24'h0, 1'b1, b_frac[51:29]};
    assign rcp_exact = rcp_quot[24];
    assign rcp_unb = rcp_exact ? -b_unb : -b_unb - 13'sh0001;

    // Root estimate: odd exponents fold into the seed index so the halving is exact.
    logic signed [12:0] rsq_even;
    logic signed [12:0] rsq_unb;
    logic [7:0] rsq_seed;
    assign rsq_even = b_unb - {12'h000, b_unb[0]};
    assign rsq_unb = -(rsq_even >>> 1) - 13'sh0001;
    assign rsq_seed = RSQRT_SEED[{b_unb[0], b_frac[51:48]}];

    // Round-to-single: 24 kept bits, one guard bit and a sticky of the rest.
    logic [1:0] rnd_mode;
    logic rnd_guard;
    logic rnd_sticky;
    logic rnd_incr;
    logic [24:0] rnd_sum;
    logic signed [12:0] rnd_unb;
    logic rnd_tiny;
    logic rnd_ovf;
    // A load in the same cycle sets the mode, just as it sets the trap enables.
    assign rnd_mode = status_load ? status_load_value[POS_ROUND_LO +: 2]
                                  : state.status[POS_ROUND_LO +: 2];
    assign rnd_guard = b_frac[28];
    assign rnd_sticky = (b_frac[27:0] != 28'h0);
    assign rnd_sum = {2'h1, b_frac[51:29]} + {24'h0, rnd_incr};
    assign rnd_unb = rnd_sum[24] ? b_unb + 13'sh0001 : b_unb;
    assign rnd_tiny = (b_unb < SGL_EXP_MIN);
    assign rnd_ovf = (rnd_unb > SGL_EXP_MAX);

    // Rounding increment for each mode of the rounding control field.
    always_comb begin
        case (rnd_mode)
            RND_NEAREST: rnd_incr = rnd_guard && (rnd_sticky || b_frac[29]);
            RND_ZERO: rnd_incr = 1'b0;
            RND_POS: rnd_incr = !b_sign && (rnd_guard || rnd_sticky);
            RND_NEG: rnd_incr = b_sign && (rnd_guard || rnd_sticky);
            default: rnd_incr = 1'b0;
        endcase
    end

    // Operation decode from the primary and extended opcode fields.
    logic do_rcp;
    logic do_rsq;
    logic do_sel;
    logic do_rsp;
    assign do_rcp = issue.valid && issue.primary == OP_SINGLE
                    && issue.extended[4:0] == XO_RECIP_EST;
    assign do_rsq = issue.valid && issue.primary == OP_DOUBLE
                    && issue.extended[4:0] == XO_RSQRT_EST;
    assign do_sel = issue.valid && issue.primary == OP_DOUBLE
                    && issue.extended[4:0] == XO_SELECT;
    assign do_rsp = issue.valid && issue.primary == OP_DOUBLE
                    && issue.extended == XO_ROUND_SINGLE;

    // Select: a NaN or a negative nonzero operand takes B, both zeros take C.
    logic a_nan;
    logic a_zero;
    logic a_ge_zero;
    assign a_nan = (issue.float_source_a[62:52] == EXP_ONES)
                   && (issue.float_source_a[51:0] != 52'h0);
    assign a_zero = (issue.float_source_a[62:0] == 63'h0);
    assign a_ge_zero = !a_nan && (!issue.float_source_a[63] || a_zero);

    // Datapath: one result per decoded operation, and one set of status updates for each except select.
    logic [63:0] value;
    logic set_ovf;
    logic set_unf;
    logic set_div0;
    logic set_inx;
    logic set_snan;
    logic set_root;
    logic ind_up;
    logic ind_inx;
    logic [31:0] base;
    logic [31:0] upd;
    logic [31:0] raised;
    logic inv_trap;
    logic div0_trap;
    logic suppress;
    always_comb begin
        next_state = state;
        value = 64'h0;
        {set_ovf, set_unf, set_div0, set_inx, set_snan, set_root} = 6'h00;
        ind_up = 1'b0;
        ind_inx = 1'b0;
        base = status_load ? status_load_value : state.status;
        upd = base;
        raised = 32'h0;
        inv_trap = base[POS_INV_TRAP];
        div0_trap = base[POS_DIV0_TRAP];
        suppress = 1'b0;
        if (do_rcp) begin
            if (b_nan) begin
                value = b_quiet;
                set_snan = b_snan;
            end else if (b_zero) begin
                value = {b_sign, EXP_ONES, 52'h0};
                set_div0 = 1'b1;
            end else if (b_inf) begin
                value = {b_sign, 63'h0};
            end else if (rcp_unb > SGL_EXP_MAX) begin
                value = {b_sign, EXP_ONES, 52'h0};
                set_ovf = 1'b1;
            end else if (rcp_unb < SGL_EXP_MIN) begin
                value = {b_sign, 63'h0};
                set_unf = 1'b1;
            end else begin
                value = {b_sign, rcp_unb[10:0] + EXP_BIAS[10:0],
                         rcp_exact ? 23'h0 : rcp_quot[22:0], 29'h0};
            end
        end else if (do_rsq) begin
            if (b_nan) begin
                value = {b_sign, EXP_ONES, 1'b1, b_frac[50:0]};
                set_snan = b_snan;
            end else if (b_zero) begin
                value = {b_sign, EXP_ONES, 52'h0};
                set_div0 = 1'b1;
            end else if (b_sign) begin
                value = DEFAULT_QNAN;
                set_root = 1'b1;
            end else if (b_inf) begin
                value = 64'h0;
            end else begin
                value = {1'b0, rsq_unb[10:0] + EXP_BIAS[10:0], rsq_seed, 44'h0};
            end
        end else if (do_rsp) begin
            if (b_nan) begin
                value = b_quiet;
                set_snan = b_snan;
            end else if (b_inf || b_zero) begin
                value = issue.float_source_b;
            end else if (rnd_tiny) begin
                value = {b_sign, 63'h0};
                set_unf = 1'b1;
                set_inx = 1'b1;
                ind_inx = 1'b1;
            end else if (rnd_ovf) begin
                set_ovf = 1'b1;
                set_inx = 1'b1;
                ind_inx = 1'b1;
                if (rnd_mode == RND_NEAREST || (rnd_mode == RND_POS && !b_sign)
                        || (rnd_mode == RND_NEG && b_sign)) begin
                    value = {b_sign, EXP_ONES, 52'h0};
                    ind_up = 1'b1;
                end else begin
                    value = {b_sign, SGL_EXP_MAX[10:0] + EXP_BIAS[10:0], 23'h7fffff, 29'h0};
                end
            end else begin
                value = {b_sign, rnd_unb[10:0] + EXP_BIAS[10:0], rnd_sum[22:0], 29'h0};
                ind_up = rnd_incr;
                ind_inx = rnd_guard || rnd_sticky;
                set_inx = ind_inx;
            end
        end else if (do_sel) begin
            value = a_ge_zero ? issue.float_source_c : issue.float_source_b;
        end
        // Trapped invalid or divide-by-zero leaves the target and class untouched.
        suppress = ((set_snan || set_root) && inv_trap)
                   || (set_div0 && div0_trap);
        if (do_rcp || do_rsq || do_rsp) begin
            // Sticky bits: each is only ever set here, so a set always survives a load.
            raised[POS_OVERFLOW] = set_ovf;
            raised[POS_UNDERFLOW] = set_unf;
            raised[POS_DIV0] = set_div0;
            raised[POS_INEXACT] = set_inx;
            raised[POS_SNAN_INV] = set_snan;
            raised[POS_ROOT_INV] = set_root;
            upd = base | raised;
            upd[POS_EXC_SUMMARY] = base[POS_EXC_SUMMARY] || ((raised & ~base) != 32'h0);
            // Rounding indicators: the estimates leave them zero, one of the undefined choices.
            upd[POS_ROUNDED_UP] = ind_up;
            upd[POS_INEXACT_RES] = ind_inx;
            if (!suppress) begin
                upd[POS_CLASS_LO +: 5] = classify(value);
            end
        end
        // The invalid and enabled summary bits are recomputed from the sticky bits and their trap enables.
        upd[POS_INV_SUMMARY] = upd[POS_SNAN_INV] || (upd[POS_INV_LO +: 5] != 5'h00)
                               || (upd[POS_INV_HI_LO +: 3] != 3'h0);
        upd[POS_EN_SUMMARY] = (upd[POS_INV_SUMMARY] && upd[POS_INV_TRAP])
                              || (upd[POS_OVERFLOW] && upd[POS_OVF_TRAP])
                              || (upd[POS_UNDERFLOW] && upd[POS_UNF_TRAP])
                              || (upd[POS_DIV0] && upd[POS_DIV0_TRAP])
                              || (upd[POS_INEXACT] && upd[POS_INEXACT_TRAP]);
        next_state.status = upd;
        next_state.res.valid = do_rcp || do_rsq || do_rsp || do_sel;
        next_state.res.write = next_state.res.valid && !suppress;
        next_state.res.target = issue.target;
        next_state.res.data = value;
        next_state.res.cond_valid = next_state.res.valid && issue.record_bit;
        next_state.res.cond_field_one = {upd[POS_EXC_SUMMARY], upd[POS_EN_SUMMARY],
                                         upd[POS_INV_SUMMARY], upd[POS_OVERFLOW]};
    end

    // State register; the status word holds its state across idle cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{res: '0, status: STATUS_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign result = state.res;
    assign float_status_control_reg = state.status;
endmodule // fp_estimate_round_select

// ==== tb/fp_est_monitor.sv ====
// Port assertions for the estimate, round and select datapath.
// Assumes one clock domain and the status layout of the package.
`timescale 1ns/100ps
module fp_est_monitor (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports.
    input wire fp_est_pkg::issue_t issue,
    input wire logic status_load,
    input wire logic [31:0] status_load_value,
    input wire fp_est_pkg::result_t result,
    input wire logic [31:0] float_status_control_reg
);
    import fp_est_pkg::*;
    logic rcp, rsq, sel, rnd, any_op, b_zero, b_snan, b_nan, b_neg, a_nan, a_take_c;
    logic [31:0] st;
    logic [4:0] cls;
    // Decode and operand classes, kept apart so that each property stays short.
    assign rcp = issue.valid && issue.primary == OP_SINGLE && issue.extended[4:0] == XO_RECIP_EST;
    assign rsq = issue.valid && issue.primary == OP_DOUBLE && issue.extended[4:0] == XO_RSQRT_EST;
    assign sel = issue.valid && issue.primary == OP_DOUBLE && issue.extended[4:0] == XO_SELECT;
    assign rnd = issue.valid && issue.primary == OP_DOUBLE && issue.extended == XO_ROUND_SINGLE;
    assign any_op = rcp || rsq || sel || rnd;
    assign st = float_status_control_reg;
    assign cls = st[POS_CLASS_LO +: 5];
    assign b_zero = issue.float_source_b[62:0] == 63'h0;
    assign b_nan = issue.float_source_b[62:52] == EXP_ONES && issue.float_source_b[51:0] != 52'h0;
    assign b_snan = b_nan && !issue.float_source_b[51];
    assign b_neg = issue.float_source_b[63] && !b_zero && !b_nan;
    assign a_nan = issue.float_source_a[62:52] == EXP_ONES && issue.float_source_a[51:0] != 52'h0;
    // A zero of either sign counts as not negative.
    assign a_take_c = !a_nan
                      && (!issue.float_source_a[63] || issue.float_source_a[62:0] == 63'h0);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_op_answer: assert property (any_op |=> result.valid)
        else $error("decoded op gave no completion");
    a_no_stray: assert property (!any_op |=> !result.valid)
        else $error("completion without a decoded op");
    a_sel_high: assert property (
        sel && a_take_c |=> result.data == $past(issue.float_source_c))
        else $error("select did not copy source c");
    a_sel_low: assert property (
        sel && !a_take_c |=> result.data == $past(issue.float_source_b))
        else $error("select did not copy source b");
    a_sel_quiet: assert property (
        sel && !status_load && !$past(status_load) |=> st == $past(st))
        else $error("select changed the status word");
    a_div0_trap: assert property (
        rcp && b_zero && st[POS_DIV0_TRAP] && !status_load
        |=> result.valid && !result.write && st[POS_DIV0])
        else $error("trapped zero divide wrote or missed its flag");
    a_class_keep: assert property (
        rcp && b_zero && st[POS_DIV0_TRAP] && !status_load |=> cls == $past(cls))
        else $error("class changed on trapped zero divide");
    a_snan_flag: assert property (
        rcp && b_snan && !status_load
        |=> st[POS_SNAN_INV] && result.write == !$past(st[POS_INV_TRAP]))
        else $error("signaling operand handled wrongly");
    a_root_neg: assert property (
        rsq && b_neg |=> st[POS_ROOT_INV] && st[POS_INV_SUMMARY])
        else $error("negative root not flagged");
    a_cond_copy: assert property (
        any_op && issue.record_bit
        |=> result.cond_valid && result.cond_field_one == st[31:28])
        else $error("field one does not mirror summaries");
    c_select: cover property (sel && a_take_c);
    c_zero_div: cover property (rcp && b_zero);
    c_round: cover property (rnd);
endmodule // fp_est_monitor

bind fp_estimate_round_select fp_est_monitor i_mon (.clk(clk), .rst_n(rst_n), .issue(issue),
    .status_load(status_load), .status_load_value(status_load_value), .result(result),
    .float_status_control_reg(float_status_control_reg));

// ==== tb/fp_issue_model.sv ====
// Issue logic and floating register file standing in front of the datapath.
// Assumes the bench calls send and idle just after rising clock edges.
`timescale 1ns/100ps
module fp_issue_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Issue out, completion back.
    output fp_est_pkg::issue_t issue,
    input wire fp_est_pkg::result_t result
);
    import fp_est_pkg::*;
    logic [63:0] fpr [32];
    initial begin
        issue = '0;
    end
    // Only completions that carry a write reach the register file.
    always_ff @(posedge clk) begin
        if (rst_n && result.valid && result.write) begin
            fpr[result.target] <= result.data;
        end
    end
    // Present one instruction, held until the next call; calls may follow back to back.
    task automatic send(input logic [5:0] p, input logic [9:0] x, input logic rc,
        input logic [4:0] t, input logic [63:0] a, input logic [63:0] b, input logic [63:0] c);
        @(posedge clk);
        #1;
        issue = '{1'b1, p, x, rc, t, a, b, c};
    endtask
    // Stale operands are inverted so that nothing can pass by reusing them.
    task automatic idle();
        @(posedge clk);
        #1;
        issue = '{1'b0, issue.primary, issue.extended, issue.record_bit, issue.target,
            ~issue.float_source_a, ~issue.float_source_b, ~issue.float_source_c};
    endtask
endmodule // fp_issue_model

// ==== tb/tb.sv ====
// Self-checking bench for the estimate, round and select datapath.
// Assumes the issue model and the bound monitor are compiled before it.
`timescale 1ns/100ps
module tb;
    import fp_est_pkg::*;
    logic clk, rst_n, status_load;
    logic [31:0] status_load_value, st;
    issue_t issue;
    result_t result;
    int err_total, total_checks;
    logic [4:0] cls;
    fp_estimate_round_select i_dut (.clk(clk), .rst_n(rst_n), .issue(issue),
        .status_load(status_load), .status_load_value(status_load_value), .result(result),
        .float_status_control_reg(st));
    fp_issue_model i_model (.clk(clk), .rst_n(rst_n), .issue(issue), .result(result));
    // Result class field, pulled out so that each check line stays short.
    assign cls = st[POS_CLASS_LO +: 5];
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [63:0] near(input real e, input real tol);
        return 64'(e < tol && e > -tol);
    endfunction
    task automatic ld(input logic [31:0] v);
        @(posedge clk);
        #1;
        status_load = 1'b1;
        status_load_value = v;
        @(posedge clk);
        #1;
        status_load = 1'b0;
    endtask
    // One op with the record bit; on return its completion is visible.
    task automatic op1(input logic [5:0] p, input logic [9:0] x, input logic [63:0] b);
        i_model.send(p, x, 1'b1, 5'h05, 64'h0, b, 64'h0);
        i_model.idle();
    endtask
    task automatic t_estimates();
        real xs [4] = '{2.0, -3.0, 1000.0, 0.3};
        real ax;
        real r;
        foreach (xs[i]) begin
            ax = xs[i] < 0 ? -xs[i] : xs[i];
            op1(OP_SINGLE, {5'h0, XO_RECIP_EST}, $realtobits(xs[i]));
            r = $bitstoreal(result.data) * xs[i];
            chk(near(r - 1.0, 1.0 / 256), 64'h1);
            chk(64'(cls), 64'(xs[i] < 0 ? CLS_NEG_NORM : CLS_POS_NORM));
            op1(OP_DOUBLE, {5'h0, XO_RSQRT_EST}, $realtobits(ax * ax));
            r = $bitstoreal(result.data) * ax;
            chk(near(r - 1.0, 1.0 / 32), 64'h1);
        end
    endtask
    // Zero and signaling operands, first untrapped and then trapped.
    task automatic t_recip_special();
        ld(32'h0);
        op1(OP_SINGLE, {5'h0, XO_RECIP_EST}, 64'h8000_0000_0000_0000);
        chk(result.data, 64'hfff0_0000_0000_0000);
        chk(64'({st[POS_DIV0], cls}), 64'({1'b1, CLS_NEG_INF}));
        op1(OP_SINGLE, {5'h0, XO_RECIP_EST}, 64'h7ff4_0000_0000_0000);
        chk(64'({result.data[62:51], st[POS_SNAN_INV]}), 64'h1fff);
        chk(64'(cls), 64'(CLS_QNAN));
        // A trapped op still completes, but writes nothing and keeps the loaded class.
        ld(32'h10);
        op1(OP_SINGLE, {5'h0, XO_RECIP_EST}, 64'h0);
        chk(64'({result.valid, result.write}), 64'h2);
        chk(64'({st[POS_DIV0], cls}), 64'h20);
        ld(32'h80);
        op1(OP_SINGLE, {5'h0, XO_RECIP_EST}, 64'hfff4_0000_0000_0000);
        chk(64'({result.valid, result.write}), 64'h2);
        chk(64'({st[POS_SNAN_INV], cls}), 64'h20);
    endtask
    task automatic t_root_special();
        logic [63:0] negs [2] = '{64'hbff0_0000_0000_0000, 64'hfff0_0000_0000_0000};
        foreach (negs[i]) begin
            ld(32'h0);
            op1(OP_DOUBLE, {5'h0, XO_RSQRT_EST}, negs[i]);
            chk(64'({result.data[62:51], st[POS_ROOT_INV]}), 64'h1fff);
        end
        op1(OP_DOUBLE, {5'h0, XO_RSQRT_EST}, 64'h7ff0_0000_0000_0000);
        chk(result.data, 64'h0);
        op1(OP_DOUBLE, {5'h0, XO_RSQRT_EST}, 64'h0);
        chk(result.data, 64'h7ff0_0000_0000_0000);
        chk(64'(st[POS_DIV0]), 64'h1);
    endtask
    // Value just above one: only rounding towards plus infinity moves it.
    task automatic t_round();
        logic [63:0] want [4] = '{64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000,
            64'h3ff0_0000_2000_0000, 64'h3ff0_0000_0000_0000};
        for (int m = 0; m < 4; m++) begin
            ld(32'(m));
            op1(OP_DOUBLE, XO_ROUND_SINGLE, 64'h3ff0_0000_0040_0000);
            chk(result.data, want[m]);
            chk(64'({st[POS_ROUNDED_UP], st[POS_INEXACT_RES]}), 64'({m == 2, 1'b1}));
            chk(64'(st[POS_INEXACT]), 64'h1);
            chk(64'(cls), 64'(CLS_POS_NORM));
        end
        ld(32'h80);
        op1(OP_DOUBLE, XO_ROUND_SINGLE, 64'h7ff4_0000_0000_0000);
        chk(64'({st[POS_SNAN_INV], cls}), 64'h20);
    endtask
    // Six selects back to back; each completion is judged while the next is issued.
    task automatic t_select();
        logic [63:0] as [6] = '{64'h3ff0_0000_0000_0000, 64'h0, 64'h8000_0000_0000_0000,
            64'hbff0_0000_0000_0000, 64'h7ff8_0000_0000_0000, 64'h7ff0_0000_0000_0000};
        logic [5:0] pick_c = 6'b100111;
        logic [63:0] want;
        ld(32'h1000_0000);
        for (int i = 0; i <= 6; i++) begin
            if (i < 6) begin
                i_model.send(OP_DOUBLE, {5'h0, XO_SELECT}, 1'b1, 5'(i), as[i], 64'hb0 + i,
                    64'hc0 + i);
            end else begin
                i_model.idle();
            end
            if (i > 0) begin
                want = (pick_c[i - 1] ? 64'hc0 : 64'hb0) + 64'(i - 1);
                chk(result.data, want);
                chk(64'(result.target), 64'(i - 1));
                chk(64'({result.cond_valid, result.cond_field_one}), 64'h11);
                chk(64'(st), 64'h1000_0000);
            end
        end
        op1(OP_DOUBLE, 10'h015, 64'h0);
        chk(64'({result.valid, result.cond_valid, st}), 64'h1000_0000);
        // Every select must have reached the register file under its own target.
        for (int k = 0; k < 6; k++) begin
            want = (pick_c[k] ? 64'hc0 : 64'hb0) + 64'(k);
            chk(i_model.fpr[k], want);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Guard against a hang anywhere in the sequence.
    initial begin
        #(100 * 20000);
        err_total++;
        test_done();
    end
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        status_load = 1'b0;
        status_load_value = 32'h0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(64'({result.valid, result.cond_valid, st}), 64'(STATUS_RESET));
        t_estimates();
        t_recip_special();
        t_root_special();
        t_round();
        t_select();
        test_done();
    end
endmodule // tb
